// >>> inc/dtpa_defines.vh
`ifndef DTPA_DEFINES_VH
`define DTPA_DEFINES_VH

// register byte addresses
`define DTPA_ADDR_SWTRIG 8'h10
`define DTPA_ADDR_PRIO 8'h14
`define DTPA_ADDR_BASE 8'h34
`define DTPA_CH_BASE 8'h40
`define DTPA_CH_SHIFT 4

// word select inside one channel window
`define DTPA_CH_CTRLA 2'h0
`define DTPA_CH_CTRLB 2'h1
`define DTPA_CH_STATE 2'h2

// reset values
`define DTPA_PRIO_RST 32'h00000000
`define DTPA_BASE_RST 32'h00000000
`define DTPA_TRIGGER_SOURCE_SELECT_RST 5'h00
`define DTPA_TRIGGER_ACTION_SELECT_RST 2'h0
`define DTPA_LVL_RST 2'h0

// priority control fields, per level l
`define DTPA_RR_EN_POS(l) (8*(l)+7)
`define DTPA_LAST_POS(l) (8*(l))
`define DTPA_LAST_W 4
`define DTPA_LEVELS 4

// channel control a
`define DTPA_CTRLA_EN_BIT 1

// channel control b
`define DTPA_CTRLB_EVEN_BIT 3
`define DTPA_CTRLB_LVL_POS 5
`define DTPA_CTRLB_TRIGGER_SOURCE_SELECT_POS 8
`define DTPA_CTRLB_TRIGGER_ACTION_SELECT_POS 22

// channel state
`define DTPA_STATE_REQUEST_PENDING_FLAG_BIT 0
`define DTPA_STATE_BUSY_BIT 1

// trigger actions
`define DTPA_ACT_BLOCK 2'h0
`define DTPA_ACT_RSVD 2'h1
`define DTPA_ACT_BEAT 2'h2
`define DTPA_ACT_TRANS 2'h3

`endif

// >>> verification/dtpa_chk.sv
`timescale 1ns/1ns
`include "dtpa_defines.vh"
module dtpa_chk #(
    parameter NCH = 4,
    parameter NPER = 8,
    parameter TSW = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // requests
    input wire logic [NPER-1:0] periphReq,
    input wire logic [NCH-1:0] eventIn,
    // grant and completion
    input wire logic grantValid,
    input wire logic [3:0] grantCh,
    input wire logic [1:0] grantAction,
    input wire logic [31:0] descBase,
    input wire logic xferDone,
    input wire logic xferBlockEnd,
    input wire logic xferLastDesc,
    // channel state
    input wire logic [NCH-1:0] chEnable,
    input wire logic [NCH-1:0] chPending,
    input wire logic [NCH-1:0] chBusy
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_unit_done;
        xferDone && grantValid;
    endsequence
    sequence s_last_done;
        s_unit_done ##0 (xferBlockEnd && xferLastDesc);
    endsequence
    property p_grant_cause;
        $rose(grantValid) |-> |($past(chPending) & (1 << grantCh))
            && |($past(chEnable) & (1 << grantCh));
    endproperty
    a_grant_cause: assert property (p_grant_cause) else $error("grant without request");
    property p_busy_tracks;
        grantValid |-> chBusy[grantCh];
    endproperty
    a_busy_tracks: assert property (p_busy_tracks) else $error("granted channel not busy");
    property p_one_busy;
        $onehot0(chBusy);
    endproperty
    a_one_busy: assert property (p_one_busy) else $error("two channels busy");
    property p_unit_ends;
        s_unit_done |-> ##[1:3] !grantValid;
    endproperty
    a_unit_ends: assert property (p_unit_ends) else $error("grant not ended");
    property p_auto_disable;
        s_last_done |-> ##[1:2] !chEnable[grantCh];
    endproperty
    a_auto_disable: assert property (p_auto_disable) else $error("no auto disable");
    property p_chain_stays;
        s_unit_done ##0 !xferLastDesc |=> chEnable[grantCh] [*2];
    endproperty
    a_chain_stays: assert property (p_chain_stays) else $error("chain channel disabled");
    property p_action_code;
        grantValid |-> grantAction != `DTPA_ACT_RSVD;
    endproperty
    a_action_code: assert property (p_action_code) else $error("reserved action");
    property p_read_idle;
        !$past(regRd) |-> regRdata == 32'h00000000;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read");
    property p_prio_reserved;
        $past(regRd) && $past(regAddr) == `DTPA_ADDR_PRIO |-> (regRdata & 32'h70707070) == 0;
    endproperty
    a_prio_reserved: assert property (p_prio_reserved) else $error("reserved bits set");
    property p_rst_clean;
        $fell(rst) |-> !grantValid && chEnable == 0;
    endproperty
    a_rst_clean: assert property (p_rst_clean) else $error("state after reset");
endmodule
bind dtpa_top dtpa_chk #(.NCH(NCH), .NPER(NPER), .TSW(TSW)) dtpa_chk_inst (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .periphReq(periphReq), .eventIn(eventIn),
    .grantValid(grantValid), .grantCh(grantCh), .grantAction(grantAction),
    .descBase(descBase), .xferDone(xferDone), .xferBlockEnd(xferBlockEnd),
    .xferLastDesc(xferLastDesc), .chEnable(chEnable), .chPending(chPending),
    .chBusy(chBusy)
);

// >>> verification/dtpa_engine_model.sv
`timescale 1ns/1ns
module dtpa_engine_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // grant from the block
    input wire logic grantValid,
    // knobs
    input wire logic [7:0] delay,
    input wire logic lastIn,
    // completion to the block
    output logic xferDone,
    output logic xferBlockEnd,
    output logic xferLastDesc
);
    logic [7:0] cnt_q;
    logic served_q;
    ////////////////////////////////////////////////////////////////////////
    // one done per grant, only while grant is shown
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            served_q <= 1'b0;
            xferDone <= 1'b0;
            xferBlockEnd <= 1'b0;
            xferLastDesc <= 1'b0;
        end else begin
            xferDone <= 1'b0;
            // levels are meaningless outside done, so keep them moving
            xferBlockEnd <= ~xferBlockEnd;
            xferLastDesc <= ~xferLastDesc;
            if (!grantValid) begin
                served_q <= 1'b0;
                cnt_q <= 8'h00;
            end else if (!served_q) begin
                if (cnt_q == delay) begin
                    xferDone <= 1'b1;
                    xferBlockEnd <= 1'b1;
                    xferLastDesc <= lastIn;
                    served_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
endmodule

// >>> verification/dtpa_top_bench.sv
`timescale 1ns/1ns
`include "dtpa_defines.vh"
module dtpa_top_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h00000000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] periphReq = 8'h00;
    logic [3:0] eventIn = 4'h0;
    logic [31:0] regRdata, descBase;
    logic grantValid, xferDone, xferBlockEnd, xferLastDesc;
    logic [3:0] grantCh, chEnable, chPending, chBusy;
    logic [1:0] grantAction;
    logic [7:0] engDelay = 8'h02;
    logic engLast = 1'b0;
    int failures = 0;
    int checks = 0;
    always #10 clk = ~clk;
    dtpa_top #(.NCH(4), .NPER(8), .TSW(5)) dtpa_top_inst (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .periphReq(periphReq), .eventIn(eventIn),
        .grantValid(grantValid), .grantCh(grantCh), .grantAction(grantAction),
        .descBase(descBase), .xferDone(xferDone), .xferBlockEnd(xferBlockEnd),
        .xferLastDesc(xferLastDesc), .chEnable(chEnable), .chPending(chPending),
        .chBusy(chBusy));
    dtpa_engine_model dtpa_engine_model_inst (
        .clk(clk), .rst(rst), .grantValid(grantValid), .delay(engDelay),
        .lastIn(engLast), .xferDone(xferDone), .xferBlockEnd(xferBlockEnd),
        .xferLastDesc(xferLastDesc));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        check(what, regRdata, exp);
    endtask
    // waits for a grant, checks it, then waits for it to end
    task automatic waitGrant(input logic [3:0] ch, input logic [1:0] act, input string what);
        int n;
        n = 0;
        while (grantValid !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) begin
            failures++;
            $display("CHECK FAILED %s expected grant seen none", what);
            give_verdict();
        end
        check(what, {26'h0, grantAction, grantCh}, {26'h0, act, ch});
        n = 0;
        while (grantValid !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) begin
            failures++;
            $display("CHECK FAILED %s end expected 0 seen 1", what);
            give_verdict();
        end
        check({what, " end"}, {31'h0, grantValid}, 32'h0);
    endtask
    task automatic noGrant(input int n, input string what);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge clk);
            seen = seen | grantValid;
        end
        check(what, {31'h0, seen}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`DTPA_ADDR_PRIO, 32'h00000000, "prio reset");
        rd(`DTPA_ADDR_BASE, 32'h00000000, "base reset");
        rd(8'hFC, 32'h00000000, "unmapped read");
        wr(`DTPA_ADDR_BASE, 32'hA5C3F00F);
        rd(`DTPA_ADDR_BASE, 32'hA5C3F00F, "base rw");
        check("desc base", descBase, 32'hA5C3F00F);
        wr(`DTPA_ADDR_PRIO, 32'hFFFFFFFF);
        rd(`DTPA_ADDR_PRIO, 32'h8F8F8F8F, "prio fields");
        $display("registers done");
        for (int i = 0; i < 4; i++) wr(8'h40 + 8'(i * 16), 32'h00000002);
        // static: nonzero last field must not change lowest-first order
        wr(`DTPA_ADDR_PRIO, 32'h00000003);
        wr(`DTPA_ADDR_SWTRIG, 32'h0000000A);
        waitGrant(4'h1, 2'h0, "static first");
        waitGrant(4'h3, 2'h0, "static second");
        rd(`DTPA_ADDR_PRIO, 32'h00000003, "static keeps last");
        // round robin: search starts after channel 1
        wr(`DTPA_ADDR_PRIO, 32'h00000081);
        wr(`DTPA_ADDR_SWTRIG, 32'h0000000A);
        waitGrant(4'h3, 2'h0, "rr first");
        waitGrant(4'h1, 2'h0, "rr second");
        rd(`DTPA_ADDR_PRIO, 32'h00000081, "rr last granted");
        wr(`DTPA_ADDR_PRIO, 32'h00000001);
        rd(`DTPA_ADDR_PRIO, 32'h00000001, "rr off keeps field");
        $display("arbitration done");
        // peripheral line 2 drives channel 0, line 0 drives nothing
        wr(8'h44, 32'h00000300);
        @(posedge clk);
        periphReq <= 8'h01;
        noGrant(8, "wrong source");
        @(posedge clk);
        periphReq <= 8'h05;
        waitGrant(4'h0, 2'h0, "peripheral trigger");
        wr(8'h54, 32'h00000008);
        @(posedge clk);
        eventIn <= 4'h2;
        @(posedge clk);
        eventIn <= 4'h0;
        waitGrant(4'h1, 2'h0, "event trigger");
        for (int k = 0; k < 3; k++) begin
            logic [1:0] act;
            act = (k == 0) ? `DTPA_ACT_BLOCK : ((k == 1) ? `DTPA_ACT_BEAT : `DTPA_ACT_TRANS);
            wr(8'h64, {8'h00, act, 22'h0});
            wr(`DTPA_ADDR_SWTRIG, 32'h00000004);
            waitGrant(4'h2, act, "trigger action");
        end
        $display("sources and actions done");
        // second trigger during a long transfer is held pending
        engDelay <= 8'h0C;
        wr(`DTPA_ADDR_SWTRIG, 32'h00000001);
        repeat (4) @(posedge clk);
        wr(`DTPA_ADDR_SWTRIG, 32'h00000001);
        rd(8'h48, 32'h00000003, "pending while busy");
        waitGrant(4'h0, 2'h0, "ongoing grant");
        waitGrant(4'h0, 2'h0, "pending grant");
        rd(8'h48, 32'h00000000, "pending cleared");
        $display("pending done");
        // last descriptor ends the channel
        engDelay <= 8'h02;
        engLast <= 1'b1;
        wr(`DTPA_ADDR_SWTRIG, 32'h00000002);
        waitGrant(4'h1, 2'h0, "last block");
        rd(8'h50, 32'h00000000, "auto disable");
        wr(`DTPA_ADDR_SWTRIG, 32'h00000002);
        wr(8'h50, 32'h00000002);
        noGrant(10, "re-enable waits");
        wr(`DTPA_ADDR_SWTRIG, 32'h00000002);
        waitGrant(4'h1, 2'h0, "new trigger");
        $display("auto disable done");
        give_verdict();
    end
endmodule

// >>> verilog/dtpa_level_pick.v
`timescale 1ns/1ns
`include "dtpa_defines.vh"

module dtpa_level_pick #(
    parameter N = 4,
    parameter IW = `DTPA_LAST_W
) (
    // requests of one level
    input wire [N-1:0] req,
    input wire rrEn,
    input wire [IW-1:0] last,
    // winner
    output reg valid,
    output reg [IW-1:0] idx
);

    integer k;
    integer c;

    always @* begin
        valid = 1'b0;
        idx = {IW{1'b0}};
        c = 0;
        for (k = 0; k < N; k = k + 1) begin
            // round robin starts one past the last grant; static ignores last
            if (rrEn) begin
                c = (last + 1 + k) % N;
            end else begin
                c = k;
            end
            if (!valid && req[c]) begin
                valid = 1'b1;
                idx = c[IW-1:0];
            end
        end
    end

endmodule

// >>> verilog/dtpa_top.v
// Behaviour
// - transfer starts only with a latched request and an arbiter grant
// - requests come from software writes, peripheral request lines or events
// - each channel selects its own trigger source
// - trigger action 0x0 requests one whole block per trigger
// - action 0x2 requests one beat, action 0x3 one transaction
// - single unlinked descriptor: enable clears when the block finishes
// - linked chain: enable clears after the last descriptor finishes
// - blocks left in chain: stay enabled, wait for next trigger
// - after re-enable, no transfer until a new trigger arrives
// - trigger during a transfer is held pending, pending bit reads 1
// - per-level round-robin enable at bits 31, 23, 15, 7
// - round robin: level field holds last granted channel, level 3 at 27:24
// - static: last granted field does not alter static order
// - clearing round-robin enable keeps the last granted field
`timescale 1ns/1ns
`include "dtpa_defines.vh"

module dtpa_top #(
    parameter NCH = 4,
    parameter NPER = 8,
    parameter TSW = 5
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [7:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata,
    // request sources
    input wire [NPER-1:0] periphReq,
    input wire [NCH-1:0] eventIn,
    // grant to the transfer engine
    output reg grantValid,
    output reg [3:0] grantCh,
    output reg [1:0] grantAction,
    output reg [31:0] descBase,
    // completion from the transfer engine
    input wire xferDone,
    input wire xferBlockEnd,
    input wire xferLastDesc,
    // channel state
    output reg [NCH-1:0] chEnable,
    output reg [NCH-1:0] chPending,
    output reg [NCH-1:0] chBusy
);

    ////////////////////////////////////////////////////////////////////////
    // state encoding

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACTIVE = 2'b10;

    ////////////////////////////////////////////////////////////////////////
    // storage

    reg [NCH-1:0] en_q;
    reg [NCH-1:0] en_d;
    reg [NCH-1:0] request_pending_flag_q;
    reg [NCH-1:0] request_pending_flag_d;
    reg [NCH-1:0] busy_q;
    reg [NCH-1:0] busy_d;
    reg [NCH-1:0] evEn_q;
    reg [NCH*TSW-1:0] trigger_source_select_q;
    reg [NCH*2-1:0] trigger_action_select_q;
    reg [NCH*2-1:0] lvl_q;
    reg [`DTPA_LEVELS-1:0] rrEn_q;
    reg [`DTPA_LEVELS*4-1:0] last_q;
    reg [31:0] base_q;
    reg [NPER-1:0] periphPrev_q;
    reg [1:0] state_q;
    reg [3:0] grantCh_q;
    reg [1:0] grantAct_q;
    reg grantValid_q;

    ////////////////////////////////////////////////////////////////////////
    // register decode

    wire [7:0] chOff;
    wire [3:0] chSel;
    wire [1:0] chReg;
    wire chHit;
    wire prioWr;
    wire baseWr;
    wire swTrigWr;

    assign chOff = regAddr - `DTPA_CH_BASE;
    assign chSel = chOff[7:`DTPA_CH_SHIFT];
    assign chReg = chOff[3:2];
    assign chHit = (regAddr >= `DTPA_CH_BASE) && (chSel < NCH);
    assign prioWr = regWr && (regAddr == `DTPA_ADDR_PRIO);
    assign baseWr = regWr && (regAddr == `DTPA_ADDR_BASE);
    assign swTrigWr = regWr && (regAddr == `DTPA_ADDR_SWTRIG);

    ////////////////////////////////////////////////////////////////////////
    // trigger detection

    wire [NPER-1:0] periphEdge;
    reg [NCH-1:0] trig;
    integer i;
    integer k;

    // peripherals share this clock, so only an edge detector is needed
    assign periphEdge = periphReq & ~periphPrev_q;

    always @* begin
        trig = {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1) begin
            // software origin, always available
            if (swTrigWr && regWdata[i]) begin
                trig[i] = 1'b1;
            end
            // peripheral origin chosen by the channel's source field
            for (k = 0; k < NPER; k = k + 1) begin
                if (trigger_source_select_q[i*TSW +: TSW] == k + 1 && periphEdge[k]) begin
                    trig[i] = 1'b1;
                end
            end
            // event origin
            if (evEn_q[i] && eventIn[i]) begin
                trig[i] = 1'b1;
            end
            // a disabled channel drops every trigger
            if (!en_q[i]) begin
                trig[i] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // arbitration

    reg [`DTPA_LEVELS*NCH-1:0] lvlReq;
    wire [`DTPA_LEVELS-1:0] lvlValid;
    wire [`DTPA_LEVELS*4-1:0] lvlIdx;
    reg winValid;
    reg [3:0] winCh;
    reg [1:0] winLvl;
    reg [1:0] winAct;
    integer l;

    always @* begin
        lvlReq = {`DTPA_LEVELS*NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1) begin
            for (l = 0; l < `DTPA_LEVELS; l = l + 1) begin
                if (lvl_q[i*2 +: 2] == l) begin
                    lvlReq[l*NCH+i] = request_pending_flag_q[i] && en_q[i] && !busy_q[i];
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `DTPA_LEVELS; g = g + 1) begin : gLvl
            dtpa_level_pick #(
                .N(NCH),
                .IW(`DTPA_LAST_W)
            ) uPick (
                .req(lvlReq[g*NCH +: NCH]),
                .rrEn(rrEn_q[g]),
                .last(last_q[g*4 +: 4]),
                .valid(lvlValid[g]),
                .idx(lvlIdx[g*4 +: 4])
            );
        end
    endgenerate

    // higher level always wins; later loop passes overwrite earlier ones
    always @* begin
        winValid = 1'b0;
        winCh = 4'h0;
        winLvl = 2'h0;
        for (l = 0; l < `DTPA_LEVELS; l = l + 1) begin
            if (lvlValid[l]) begin
                winValid = 1'b1;
                winCh = lvlIdx[l*4 +: 4];
                winLvl = l[1:0];
            end
        end
    end

    // reserved action code is run as a block request
    always @* begin
        winAct = trigger_action_select_q[winCh*2 +: 2];
        if (winAct == `DTPA_ACT_RSVD) begin
            winAct = `DTPA_ACT_BLOCK;
        end
    end

    wire grantNow;
    wire doneNow;
    wire autoOff;

    assign grantNow = (state_q == ST_IDLE) && winValid;
    assign doneNow = (state_q == ST_ACTIVE) && xferDone;
    assign autoOff = doneNow && xferBlockEnd && xferLastDesc;

    ////////////////////////////////////////////////////////////////////////
    // grant state machine

    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            grantValid_q <= 1'b0;
            grantCh_q <= 4'h0;
            grantAct_q <= `DTPA_ACT_BLOCK;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (winValid) begin
                        state_q <= ST_ACTIVE;
                        grantValid_q <= 1'b1;
                        grantCh_q <= winCh;
                        // beat or transaction sizes the unit of one grant
                        grantAct_q <= winAct;
                    end
                end
                ST_ACTIVE: begin
                    if (xferDone) begin
                        state_q <= ST_IDLE;
                        grantValid_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    grantValid_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel enable, pending and busy

    always @* begin
        en_d = en_q;
        request_pending_flag_d = request_pending_flag_q;
        busy_d = busy_q;
        for (i = 0; i < NCH; i = i + 1) begin
            if (regWr && chHit && chReg == `DTPA_CH_CTRLA && chSel == i) begin
                en_d[i] = regWdata[`DTPA_CTRLA_EN_BIT];
            end
            // grant consumes the pending request
            if (grantNow && winCh == i) begin
                request_pending_flag_d[i] = 1'b0;
                busy_d[i] = 1'b1;
            end
            if (doneNow && grantCh_q == i) begin
                busy_d[i] = 1'b0;
            end
            // new trigger wins over the grant's clear; a second one is lost
            if (trig[i]) begin
                request_pending_flag_d[i] = 1'b1;
            end
            // last descriptor of the granted channel finished: its enable clears
            if (autoOff && grantCh_q == i) begin
                en_d[i] = 1'b0;
            end
            // a stale request must not survive a disable
            if (!en_d[i]) begin
                request_pending_flag_d[i] = 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            en_q <= {NCH{1'b0}};
            request_pending_flag_q <= {NCH{1'b0}};
            busy_q <= {NCH{1'b0}};
            periphPrev_q <= {NPER{1'b0}};
        end else begin
            en_q <= en_d;
            request_pending_flag_q <= request_pending_flag_d;
            busy_q <= busy_d;
            periphPrev_q <= periphReq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel configuration

    always @(posedge clk) begin
        if (rst) begin
            evEn_q <= {NCH{1'b0}};
            trigger_source_select_q <= {NCH{`DTPA_TRIGGER_SOURCE_SELECT_RST}};
            trigger_action_select_q <= {NCH{`DTPA_TRIGGER_ACTION_SELECT_RST}};
            lvl_q <= {NCH{`DTPA_LVL_RST}};
        end else begin
            for (i = 0; i < NCH; i = i + 1) begin
                if (regWr && chHit && chReg == `DTPA_CH_CTRLB && chSel == i) begin
                    evEn_q[i] <= regWdata[`DTPA_CTRLB_EVEN_BIT];
                    lvl_q[i*2 +: 2] <= regWdata[`DTPA_CTRLB_LVL_POS +: 2];
                    trigger_source_select_q[i*TSW +: TSW] <= regWdata[`DTPA_CTRLB_TRIGGER_SOURCE_SELECT_POS +: TSW];
                    trigger_action_select_q[i*2 +: 2] <= regWdata[`DTPA_CTRLB_TRIGGER_ACTION_SELECT_POS +: 2];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // priority control and descriptor base

    always @(posedge clk) begin
        if (rst) begin
            rrEn_q <= {`DTPA_LEVELS{1'b0}};
            last_q <= {`DTPA_LEVELS*4{1'b0}};
            base_q <= `DTPA_BASE_RST;
        end else begin
            if (prioWr) begin
                for (l = 0; l < `DTPA_LEVELS; l = l + 1) begin
                    rrEn_q[l] <= regWdata[`DTPA_RR_EN_POS(l)];
                    // only software touches the field when the enable drops
                    last_q[l*4 +: 4] <= regWdata[`DTPA_LAST_POS(l) +: 4];
                end
            end
            // hardware update wins over a software write in the same cycle
            if (grantNow && rrEn_q[winLvl]) begin
                last_q[winLvl*4 +: 4] <= winCh;
            end
            if (baseWr) begin
                base_q <= regWdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    reg [31:0] rdMux;

    always @* begin
        rdMux = 32'h00000000;
        if (regAddr == `DTPA_ADDR_PRIO) begin
            for (l = 0; l < `DTPA_LEVELS; l = l + 1) begin
                rdMux[`DTPA_RR_EN_POS(l)] = rrEn_q[l];
                rdMux[`DTPA_LAST_POS(l) +: 4] = last_q[l*4 +: 4];
            end
        end else if (regAddr == `DTPA_ADDR_BASE) begin
            rdMux = base_q;
        end else if (chHit) begin
            for (i = 0; i < NCH; i = i + 1) begin
                if (chSel == i) begin
                    case (chReg)
                        `DTPA_CH_CTRLA: begin
                            rdMux[`DTPA_CTRLA_EN_BIT] = en_q[i];
                        end
                        `DTPA_CH_CTRLB: begin
                            rdMux[`DTPA_CTRLB_EVEN_BIT] = evEn_q[i];
                            rdMux[`DTPA_CTRLB_LVL_POS +: 2] = lvl_q[i*2 +: 2];
                            rdMux[`DTPA_CTRLB_TRIGGER_SOURCE_SELECT_POS +: TSW] = trigger_source_select_q[i*TSW +: TSW];
                            rdMux[`DTPA_CTRLB_TRIGGER_ACTION_SELECT_POS +: 2] = trigger_action_select_q[i*2 +: 2];
                        end
                        `DTPA_CH_STATE: begin
                            rdMux[`DTPA_STATE_REQUEST_PENDING_FLAG_BIT] = request_pending_flag_q[i];
                            rdMux[`DTPA_STATE_BUSY_BIT] = busy_q[i];
                        end
                        default: begin
                            rdMux = 32'h00000000;
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output flops

    // outputs are a cycle behind the state so every port comes from a flop
    always @(posedge clk) begin
        if (rst) begin
            regRdata <= 32'h00000000;
            grantValid <= 1'b0;
            grantCh <= 4'h0;
            grantAction <= `DTPA_ACT_BLOCK;
            descBase <= `DTPA_BASE_RST;
            chEnable <= {NCH{1'b0}};
            chPending <= {NCH{1'b0}};
            chBusy <= {NCH{1'b0}};
        end else begin
            regRdata <= regRd ? rdMux : 32'h00000000;
            grantValid <= grantValid_q;
            grantCh <= grantCh_q;
            grantAction <= grantAct_q;
            descBase <= base_q;
            chEnable <= en_q;
            chPending <= request_pending_flag_q;
            chBusy <= busy_q;
        end
    end

endmodule
